// ===== src/clock_sysref_pkg.sv
// Constants for the clock, alignment-pulse and full-scale register bank
package clock_sysref_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CAPTURE_W = 24;
    localparam int FS_W = 16;
    localparam int SAMPLE_W = 12;

    // Byte addresses; wide registers put their low byte at the lowest address
    localparam logic [ADDR_W-1:0] ADDR_CLOCK_CONTROL_ONE = 15'h002A;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK_CONTROL_TWO = 15'h002B;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE_POS_B0 = 15'h002C;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE_POS_B1 = 15'h002D;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE_POS_B2 = 15'h002E;
    localparam logic [ADDR_W-1:0] ADDR_FULL_SCALE_A_LO = 15'h0030;
    localparam logic [ADDR_W-1:0] ADDR_FULL_SCALE_A_HI = 15'h0031;
    localparam logic [ADDR_W-1:0] ADDR_FULL_SCALE_B_LO = 15'h0032;
    localparam logic [ADDR_W-1:0] ADDR_FULL_SCALE_B_HI = 15'h0033;
    localparam logic [ADDR_W-1:0] ADDR_REFERENCE_BYPASS = 15'h0038;

    // Reset values
    localparam logic [DATA_W-1:0] RST_CLOCK_CONTROL_ONE = 8'h00;
    localparam logic [DATA_W-1:0] RST_CLOCK_CONTROL_TWO = 8'h11;
    localparam logic [CAPTURE_W-1:0] RST_CAPTURE_POS = 24'h000000;
    localparam logic [FS_W-1:0] RST_FULL_SCALE = 16'hA000;
    localparam logic [DATA_W-1:0] RST_REFERENCE_BYPASS = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

    // Field positions in clock_control_one
    localparam int BIT_ALIGN_PULSE_TIMESTAMP_ENABLE = 3;
    localparam int BIT_DEVICE_CLOCK_PECL_MODE = 2;
    localparam int BIT_ALIGN_PULSE_PECL_MODE = 1;
    localparam int BIT_ALIGN_PULSE_INVERT = 0;

    // Field positions in clock_control_two
    localparam int BIT_CLOCK_FEEDBACK_GAIN = 4;
    localparam int BIT_ANALOG_SUPPLY_NOISE_SUPPRESS = 2;
    localparam int SAMPLING_CLOCK_DELAY_LSB = 0;
    localparam int SAMPLING_CLOCK_DELAY_W = 2;

    // Field position in reference_bypass
    localparam int BIT_REFERENCE_BYPASS = 0;

endpackage

// ===== src/sample_stream_if.sv
// Sample path and timestamp controls between the register bank and the inserter
`timescale 1ns/1ns
interface sample_stream_if #(
    parameter int SAMPLE_W = 12
) ();
    logic [SAMPLE_W-1:0] sample_in;
    logic sample_valid_in;
    logic align_pulse;
    logic align_pulse_invert;
    logic align_pulse_timestamp_enable;
    logic global_timestamp_enable;
    logic decimation_bypass;
    logic [SAMPLE_W-1:0] sample_out;
    logic sample_valid_out;
    logic align_pulse_used;

    modport bank (
        output sample_in, sample_valid_in, align_pulse, align_pulse_invert,
        output align_pulse_timestamp_enable, global_timestamp_enable, decimation_bypass,
        input sample_out, sample_valid_out, align_pulse_used
    );
    modport inserter (
        input sample_in, sample_valid_in, align_pulse, align_pulse_invert,
        input align_pulse_timestamp_enable, global_timestamp_enable, decimation_bypass,
        output sample_out, sample_valid_out, align_pulse_used
    );
endinterface

// ===== src/timestamp_insert.sv
// Alignment-pulse polarity and timestamp insertion on the sample path
`timescale 1ns/1ns
module timestamp_insert (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    sample_stream_if.inserter st
);
    import clock_sysref_pkg::*;

    logic [$bits(st.sample_out)-1:0] sample_q;
    logic [$bits(st.sample_out)-1:0] next_sample_q;
    logic valid_q;
    logic next_valid_q;
    logic pulse_q;
    logic next_pulse_q;
    logic pulse_now;
    logic insert_on;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        pulse_now = st.align_pulse ^ st.align_pulse_invert;
        // Only the undecimated stream carries the marker
        insert_on = st.align_pulse_timestamp_enable && st.global_timestamp_enable
            && st.decimation_bypass;
        next_pulse_q = pulse_now;
        next_valid_q = st.sample_valid_in;
        next_sample_q = sample_q;
        if (st.sample_valid_in) begin
            next_sample_q = st.sample_in;
            if (insert_on) begin
                next_sample_q[0] = pulse_now;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_q <= '0;
            valid_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            sample_q <= next_sample_q;
            valid_q <= next_valid_q;
            pulse_q <= next_pulse_q;
        end
    end

    assign st.sample_out = sample_q;
    assign st.sample_valid_out = valid_q;
    assign st.align_pulse_used = pulse_q;

    ////////////////////////////////////////////////////////////////////////////
    ts_insert_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        st.sample_valid_in && st.align_pulse_timestamp_enable && st.global_timestamp_enable
        && st.decimation_bypass |=> st.sample_out[0] == st.align_pulse_used)
        else $error("timestamp bit not carried on sample lsb");

    decim_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        st.sample_valid_in && !st.decimation_bypass |=> st.sample_out == $past(st.sample_in))
        else $error("sample altered while decimating");

    pulse_invert_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        1'b1 |=> st.align_pulse_used == $past(st.align_pulse ^ st.align_pulse_invert))
        else $error("alignment pulse polarity wrong");

    ts_seen_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
        st.sample_valid_in && st.align_pulse_timestamp_enable && st.global_timestamp_enable
        && st.decimation_bypass && st.align_pulse);
endmodule

// ===== src/clock_sysref_range_regs.sv
// Clock, alignment-pulse, capture-position, full-scale and reference-bypass registers
`timescale 1ns/1ns
module clock_sysref_range_regs #(
    parameter int SAMPLE_W = clock_sysref_pkg::SAMPLE_W
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [clock_sysref_pkg::ADDR_W-1:0] cfg_addr_i,
    input wire logic cfg_wr_i,
    input wire logic [clock_sysref_pkg::DATA_W-1:0] cfg_wdata_i,
    input wire logic cfg_rd_i,
    output logic [clock_sysref_pkg::DATA_W-1:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic capture_valid_i,
    input wire logic [clock_sysref_pkg::CAPTURE_W-1:0] capture_word_i,
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic sample_valid_i,
    input wire logic align_pulse_i,
    input wire logic global_timestamp_enable_i,
    input wire logic decimation_bypass_i,
    output logic [SAMPLE_W-1:0] sample_o,
    output logic sample_valid_o,
    output logic align_pulse_used_o,
    output logic device_clock_pecl_mode_o,
    output logic align_pulse_pecl_mode_o,
    output logic clock_feedback_gain_o,
    output logic analog_supply_noise_suppress_o,
    output logic [clock_sysref_pkg::SAMPLING_CLOCK_DELAY_W-1:0] sampling_clock_delay_o,
    output logic [clock_sysref_pkg::FS_W-1:0] full_scale_input_a_o,
    output logic [clock_sysref_pkg::FS_W-1:0] full_scale_input_b_o,
    output logic reference_bypass_o
);
    import clock_sysref_pkg::*;

    logic [DATA_W-1:0] clock_control_one;
    logic [DATA_W-1:0] next_clock_control_one;
    logic [DATA_W-1:0] clock_control_two;
    logic [DATA_W-1:0] next_clock_control_two;
    logic [CAPTURE_W-1:0] align_pulse_capture_position;
    logic [CAPTURE_W-1:0] next_align_pulse_capture_position;
    logic [FS_W-1:0] full_scale_input_a;
    logic [FS_W-1:0] next_full_scale_input_a;
    logic [FS_W-1:0] full_scale_input_b;
    logic [FS_W-1:0] next_full_scale_input_b;
    logic [DATA_W-1:0] reference_bypass;
    logic [DATA_W-1:0] next_reference_bypass;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic rvalid;
    logic next_rvalid;

    sample_stream_if #(.SAMPLE_W(SAMPLE_W)) st ();

    // Replace one byte of a 16-bit word
    function automatic logic [FS_W-1:0] put_byte(
        input logic [FS_W-1:0] word,
        input logic high,
        input logic [DATA_W-1:0] data
    );
        logic [FS_W-1:0] result;
        result = word;
        if (high) begin
            result[FS_W-1:DATA_W] = data;
        end else begin
            result[DATA_W-1:0] = data;
        end
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and status capture
    always_comb begin
        next_clock_control_one = clock_control_one;
        next_clock_control_two = clock_control_two;
        next_full_scale_input_a = full_scale_input_a;
        next_full_scale_input_b = full_scale_input_b;
        next_reference_bypass = reference_bypass;
        next_align_pulse_capture_position = align_pulse_capture_position;
        // Hardware is the only writer; host writes to these bytes are dropped
        if (capture_valid_i) begin
            next_align_pulse_capture_position = capture_word_i;
        end
        if (cfg_wr_i) begin
            unique case (cfg_addr_i)
                ADDR_CLOCK_CONTROL_ONE: begin
                    next_clock_control_one = cfg_wdata_i;
                end
                ADDR_CLOCK_CONTROL_TWO: begin
                    next_clock_control_two = cfg_wdata_i;
                end
                ADDR_FULL_SCALE_A_LO: begin
                    next_full_scale_input_a = put_byte(full_scale_input_a, 1'b0, cfg_wdata_i);
                end
                ADDR_FULL_SCALE_A_HI: begin
                    next_full_scale_input_a = put_byte(full_scale_input_a, 1'b1, cfg_wdata_i);
                end
                ADDR_FULL_SCALE_B_LO: begin
                    next_full_scale_input_b = put_byte(full_scale_input_b, 1'b0, cfg_wdata_i);
                end
                ADDR_FULL_SCALE_B_HI: begin
                    next_full_scale_input_b = put_byte(full_scale_input_b, 1'b1, cfg_wdata_i);
                end
                ADDR_REFERENCE_BYPASS: begin
                    next_reference_bypass = cfg_wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clock_control_one <= RST_CLOCK_CONTROL_ONE;
            clock_control_two <= RST_CLOCK_CONTROL_TWO;
            align_pulse_capture_position <= RST_CAPTURE_POS;
            full_scale_input_a <= RST_FULL_SCALE;
            full_scale_input_b <= RST_FULL_SCALE;
            reference_bypass <= RST_REFERENCE_BYPASS;
        end else begin
            clock_control_one <= next_clock_control_one;
            clock_control_two <= next_clock_control_two;
            align_pulse_capture_position <= next_align_pulse_capture_position;
            full_scale_input_a <= next_full_scale_input_a;
            full_scale_input_b <= next_full_scale_input_b;
            reference_bypass <= next_reference_bypass;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port; a read in the cycle of a write returns the old value
    always_comb begin
        next_rvalid = cfg_rd_i;
        next_rdata = rdata;
        if (cfg_rd_i) begin
            unique case (cfg_addr_i)
                ADDR_CLOCK_CONTROL_ONE: next_rdata = clock_control_one;
                ADDR_CLOCK_CONTROL_TWO: next_rdata = clock_control_two;
                ADDR_CAPTURE_POS_B0: next_rdata = align_pulse_capture_position[7:0];
                ADDR_CAPTURE_POS_B1: next_rdata = align_pulse_capture_position[15:8];
                ADDR_CAPTURE_POS_B2: next_rdata = align_pulse_capture_position[23:16];
                ADDR_FULL_SCALE_A_LO: next_rdata = full_scale_input_a[7:0];
                ADDR_FULL_SCALE_A_HI: next_rdata = full_scale_input_a[15:8];
                ADDR_FULL_SCALE_B_LO: next_rdata = full_scale_input_b[7:0];
                ADDR_FULL_SCALE_B_HI: next_rdata = full_scale_input_b[15:8];
                ADDR_REFERENCE_BYPASS: next_rdata = reference_bypass;
                default: next_rdata = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata <= READ_UNMAPPED;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign cfg_rdata_o = rdata;
    assign cfg_rvalid_o = rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // Analog controls straight from the register flops
    assign device_clock_pecl_mode_o = clock_control_one[BIT_DEVICE_CLOCK_PECL_MODE];
    assign align_pulse_pecl_mode_o = clock_control_one[BIT_ALIGN_PULSE_PECL_MODE];
    assign clock_feedback_gain_o = clock_control_two[BIT_CLOCK_FEEDBACK_GAIN];
    assign analog_supply_noise_suppress_o =
        clock_control_two[BIT_ANALOG_SUPPLY_NOISE_SUPPRESS];
    // No one-hot check: an illegal code is passed on as written
    assign sampling_clock_delay_o = clock_control_two[SAMPLING_CLOCK_DELAY_LSB +:
        SAMPLING_CLOCK_DELAY_W];
    assign full_scale_input_a_o = full_scale_input_a;
    assign full_scale_input_b_o = full_scale_input_b;
    assign reference_bypass_o = reference_bypass[BIT_REFERENCE_BYPASS];

    ////////////////////////////////////////////////////////////////////////////
    // Sample path
    assign st.sample_in = sample_i;
    assign st.sample_valid_in = sample_valid_i;
    assign st.align_pulse = align_pulse_i;
    assign st.align_pulse_invert = clock_control_one[BIT_ALIGN_PULSE_INVERT];
    assign st.align_pulse_timestamp_enable =
        clock_control_one[BIT_ALIGN_PULSE_TIMESTAMP_ENABLE];
    assign st.global_timestamp_enable = global_timestamp_enable_i;
    assign st.decimation_bypass = decimation_bypass_i;
    assign sample_o = st.sample_out;
    assign sample_valid_o = st.sample_valid_out;
    assign align_pulse_used_o = st.align_pulse_used;

    timestamp_insert u_insert (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .st(st.inserter)
    );

    ////////////////////////////////////////////////////////////////////////////
    clk_pecl_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && cfg_addr_i == ADDR_CLOCK_CONTROL_ONE
        |=> device_clock_pecl_mode_o == $past(cfg_wdata_i[BIT_DEVICE_CLOCK_PECL_MODE]))
        else $error("device clock pecl mode not taken from write");

    pulse_pecl_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && cfg_addr_i == ADDR_CLOCK_CONTROL_ONE
        |=> align_pulse_pecl_mode_o == $past(cfg_wdata_i[BIT_ALIGN_PULSE_PECL_MODE]))
        else $error("pulse pecl mode not taken from write");

    ctrl_one_reset_a: assert property (@(posedge clk_sys_i)
        $rose(rstn_i) |-> clock_control_one == 8'h00 && !device_clock_pecl_mode_o)
        else $error("clock control one reset value wrong");

    ctrl_two_reset_a: assert property (@(posedge clk_sys_i)
        $rose(rstn_i) |-> clock_control_two == 8'h11 && clock_feedback_gain_o
        && sampling_clock_delay_o == 2'h1)
        else $error("clock control two reset value wrong");

    noise_suppress_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && cfg_addr_i == ADDR_CLOCK_CONTROL_TWO ##1 !cfg_wr_i
        |-> analog_supply_noise_suppress_o == $past(cfg_wdata_i[2]))
        else $error("noise suppression does not follow bit 2");

    clk_delay_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && cfg_addr_i == ADDR_CLOCK_CONTROL_TWO
        |=> sampling_clock_delay_o == $past(cfg_wdata_i[1:0]))
        else $error("sampling clock delay not taken from write");

    capture_take_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        capture_valid_i ##1 cfg_rd_i && cfg_addr_i == ADDR_CAPTURE_POS_B2
        |=> cfg_rvalid_o && cfg_rdata_o == $past(capture_word_i[23:16], 2))
        else $error("capture word not returned");

    capture_ro_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && !capture_valid_i |=> $stable(align_pulse_capture_position))
        else $error("capture position changed by host write");

    capture_wr_drop_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && cfg_addr_i == ADDR_CAPTURE_POS_B0 && !capture_valid_i
        |=> align_pulse_capture_position == $past(align_pulse_capture_position))
        else $error("host write reached capture position");

    fs_a_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && cfg_addr_i == ADDR_FULL_SCALE_A_HI
        |=> full_scale_input_a_o[15:8] == $past(cfg_wdata_i)
        && $stable(full_scale_input_a_o[7:0]))
        else $error("full scale a high byte write wrong");

    fs_b_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && cfg_addr_i == ADDR_FULL_SCALE_B_LO
        |=> full_scale_input_b_o[7:0] == $past(cfg_wdata_i)
        && $stable(full_scale_input_b_o[15:8]))
        else $error("full scale b low byte write wrong");

    fs_reset_a: assert property (@(posedge clk_sys_i)
        $rose(rstn_i) |-> full_scale_input_a_o == 16'hA000 && full_scale_input_b_o == 16'hA000)
        else $error("full scale reset value wrong");

    bypass_reset_a: assert property (@(posedge clk_sys_i)
        $rose(rstn_i) |-> reference_bypass == 8'h00 && !reference_bypass_o)
        else $error("reference bypass reset value wrong");

    bypass_bit_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && cfg_addr_i == ADDR_REFERENCE_BYPASS
        |=> reference_bypass_o == $past(cfg_wdata_i[0]))
        else $error("reference bypass bit not applied");

    readback_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && cfg_addr_i == ADDR_CLOCK_CONTROL_ONE ##1
        cfg_rd_i && cfg_addr_i == ADDR_CLOCK_CONTROL_ONE
        |=> cfg_rvalid_o && cfg_rdata_o == $past(cfg_wdata_i, 2))
        else $error("read back differs from last write");

    write_read_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_wr_i && cfg_addr_i == ADDR_FULL_SCALE_A_LO ##1
        cfg_rd_i && cfg_addr_i == ADDR_FULL_SCALE_A_LO);

    capture_read_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
        capture_valid_i ##[1:4] cfg_rd_i && cfg_addr_i == ADDR_CAPTURE_POS_B0);

    unmapped_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cfg_rd_i && cfg_addr_i == 15'h0034);

    reset_release_c: cover property (@(posedge clk_sys_i) $rose(rstn_i));
endmodule

// ===== verification/clock_sysref_range_regs_tb.sv
// Self-checking bench for the clock, pulse, capture and full-scale registers
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
    $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module clock_sysref_range_regs_tb;
import clock_sysref_pkg::*;
typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [DATA_W-1:0] e;} row_t;
logic clk_sys_i = 0;
logic rstn_i = 0;
logic [ADDR_W-1:0] addr = '0;
logic wr = 0;
logic rd = 0;
logic [DATA_W-1:0] wdata = '0;
logic cap_v = 0;
logic [CAPTURE_W-1:0] cap_w = '0;
logic [11:0] smp = '0;
logic smp_v = 0;
logic pulse = 0;
logic gts = 0;
logic byp = 0;
logic [DATA_W-1:0] rdata;
logic rvalid;
logic [11:0] smp_o;
logic smp_v_o, used_o, dpecl, apecl, gain, noise, refb;
logic [1:0] dly;
logic [FS_W-1:0] fsa, fsb;
int err_total = 0;
int tests_run = 0;
int cyc = 0;
row_t rows[9] = '{'{15'h002A, 8'hF5, 8'hF5}, '{15'h002B, 8'hEE, 8'hEE},
    '{15'h0030, 8'h34, 8'h34}, '{15'h0031, 8'h12, 8'h12}, '{15'h0032, 8'h78, 8'h78},
    '{15'h0033, 8'hFF, 8'hFF}, '{15'h0038, 8'hFF, 8'hFF}, '{15'h002C, 8'hAA, 8'h00},
    '{15'h0040, 8'h55, 8'h00}};
clock_sysref_range_regs DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cfg_addr_i(addr),
    .cfg_wr_i(wr), .cfg_wdata_i(wdata), .cfg_rd_i(rd), .cfg_rdata_o(rdata),
    .cfg_rvalid_o(rvalid), .capture_valid_i(cap_v), .capture_word_i(cap_w),
    .sample_i(smp), .sample_valid_i(smp_v), .align_pulse_i(pulse),
    .global_timestamp_enable_i(gts), .decimation_bypass_i(byp), .sample_o(smp_o),
    .sample_valid_o(smp_v_o), .align_pulse_used_o(used_o), .device_clock_pecl_mode_o(dpecl),
    .align_pulse_pecl_mode_o(apecl), .clock_feedback_gain_o(gain),
    .analog_supply_noise_suppress_o(noise), .sampling_clock_delay_o(dly),
    .full_scale_input_a_o(fsa), .full_scale_input_b_o(fsb), .reference_bypass_o(refb));
always #20 clk_sys_i = ~clk_sys_i;
////////////////////////////////////////////////////////////////////////////////
task automatic wr_byte(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_i);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
endtask
task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_sys_i);
    addr <= a; rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(negedge clk_sys_i);
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
endtask
// Write then read the same byte on the very next edge
task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_i);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0; rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(negedge clk_sys_i);
    `CHK("b2b rvalid", 1'b1, rvalid)
    `CHK("b2b rdata", d, rdata)
endtask
task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
// Bound well above the roughly 85 cycles the sequence needs
always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
        err_total++;
        finish_test();
    end
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd_chk(15'h002A, 8'h00);
    rd_chk(15'h002B, 8'h11);
    `CHK("delay", 2'b01, dly)
    `CHK("gain", 1'b1, gain)
    rd_chk(15'h0031, 8'hA0);
    rd_chk(15'h0033, 8'hA0);
    rd_chk(15'h0038, 8'h00);
    foreach (rows[i]) begin
        wr_byte(rows[i].a, rows[i].d);
        rd_chk(rows[i].a, rows[i].e);
    end
    `CHK("dclk pecl", 1'b1, dpecl)
    `CHK("pulse pecl", 1'b0, apecl)
    `CHK("gain", 1'b0, gain)
    `CHK("noise", 1'b1, noise)
    `CHK("delay", 2'b10, dly)
    `CHK("fs a", 16'h1234, fsa)
    `CHK("fs b", 16'hFF78, fsb)
    `CHK("ref", 1'b1, refb)
    // Capture word arrives whole; host writes to it were dropped above
    @(posedge clk_sys_i);
    cap_v <= 1'b1; cap_w <= 24'h123456;
    @(posedge clk_sys_i);
    cap_v <= 1'b0; addr <= 15'h002E; rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(negedge clk_sys_i);
    `CHK("cap rvalid", 1'b1, rvalid)
    `CHK("cap hi", 8'h12, rdata)
    rd_chk(15'h002C, 8'h56);
    rd_chk(15'h002D, 8'h34);
    // Stamp bit plus inversion, then the same sample with decimation active
    wr_byte(15'h002A, 8'h09);
    @(posedge clk_sys_i);
    smp <= 12'hFFE; smp_v <= 1'b1; gts <= 1'b1; byp <= 1'b1;
    @(posedge clk_sys_i);
    byp <= 1'b0;
    @(negedge clk_sys_i);
    `CHK("stamped", 12'hFFF, smp_o)
    `CHK("used", 1'b1, used_o)
    `CHK("valid", 1'b1, smp_v_o)
    @(posedge clk_sys_i);
    smp_v <= 1'b0;
    @(negedge clk_sys_i);
    `CHK("no stamp", 12'hFFE, smp_o)
    // Pulse high with inversion on: lsb must carry the inverted level
    @(posedge clk_sys_i);
    pulse <= 1'b1; smp <= 12'h001; smp_v <= 1'b1; byp <= 1'b1;
    @(posedge clk_sys_i);
    smp_v <= 1'b0; pulse <= 1'b0;
    @(negedge clk_sys_i);
    `CHK("pulse stamp", 12'h000, smp_o)
    `CHK("pulse used", 1'b0, used_o)
    wr_rd(15'h002A, 8'hA5);
    wr_rd(15'h0030, 8'h5A);
    // Second reset mid-run restores defaults
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd_chk(15'h002B, 8'h11);
    rd_chk(15'h0030, 8'h00);
    finish_test();
end
endmodule
